// *** hw/slpx_fifo.sv ***
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps

module slpx_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,     // system clock
    input  wire logic             i_rst_n,   // synchronised reset, active low
    input  wire logic             i_valid,   // write side offers a word
    output logic                  o_ready,   // room for a word
    input  wire logic [WIDTH-1:0] i_data,    // word in
    output logic                  o_valid,   // a word is waiting
    input  wire logic             i_ready,   // read side takes the word
    output logic [WIDTH-1:0]      o_data     // oldest word
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    // handshakes; full and empty come straight from the count
    assign o_ready = (count_reg != (AW+1)'(DEPTH));
    assign o_valid = (count_reg != '0);
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign o_data  = mem[rd_ptr_reg];

    // storage carries no reset, only pointers and count are control state
    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wr_ptr_reg] <= i_data;
    end

    // pointers wrap at depth
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end

endmodule

// *** hw/slpx_pkg.sv ***
// types shared by the serial led port expander front end
package slpx_pkg;

    // what the shared pin does
    typedef enum logic
    {
        SLPX_PIN_DOUT  = 1'b0,
        SLPX_PIN_CLKIN = 1'b1
    } slpx_pin_mode_e;

    // what a port does, decoded from its output code
    typedef enum logic [2:0]
    {
        SLPX_FN_LOW    = 3'b000,
        SLPX_FN_HIGH   = 3'b001,
        SLPX_FN_STATIC = 3'b010,
        SLPX_FN_PWM    = 3'b011,
        SLPX_FN_OFF    = 3'b100
    } slpx_port_fn_e;

    // word capture state
    typedef enum logic
    {
        SLPX_CAP_IDLE = 1'b0,
        SLPX_CAP_PEND = 1'b1
    } slpx_cap_e;

    typedef logic [7:0] slpx_code_t;

endpackage

// *** hw/slpx_regs.svh ***
// register addresses, field positions, reset values and timing counts
`ifndef SLPX_REGS_SVH
`define SLPX_REGS_SVH

// word layout: address byte above data byte
`define SLPX_WORD_W        16
`define SLPX_ADDR_HI       15
`define SLPX_ADDR_LO       8
`define SLPX_DATA_HI       7
`define SLPX_DATA_LO       0

// register addresses
`define SLPX_A_PORT_FIRST  8'h00
`define SLPX_A_PORT_LAST   8'h09
`define SLPX_A_CFG         8'h10
`define SLPX_A_FULL_LO     8'h11
`define SLPX_A_FULL_HI     8'h12
`define SLPX_A_GCUR        8'h13

// configuration register fields
`define SLPX_CFG_RUN       0
`define SLPX_CFG_PINCLK    1

// port output codes
`define SLPX_CODE_LOW      8'h00
`define SLPX_CODE_HIGH     8'h01
`define SLPX_CODE_STATIC   8'h02
`define SLPX_CODE_PWM_MIN  8'h03
`define SLPX_CODE_PWM_MAX  8'hFE
`define SLPX_CODE_OFF      8'hFF

// reset values
`define SLPX_RST_CODE      8'hFF
`define SLPX_RST_GCUR      3'h7
`define SLPX_RST_FULL      10'h000

// internal pwm timebase
`define SLPX_SYS_CLK_HZ    125000000
`define SLPX_INT_PWM_HZ    32000
`define SLPX_INT_DIV       (`SLPX_SYS_CLK_HZ / `SLPX_INT_PWM_HZ)

// fifo in the word path
`define SLPX_FIFO_DEPTH    8

`endif

// *** hw/slpx_top.sv ***
// serial front end of a ten port led driver and i/o expander
//
// How it works
// - each rising serial clock edge with chip select low shifts the data bit into a 16-bit register
// - in data-output mode the echo output changes on falling serial clock edges
// - serial clock edges count only while chip select is low
// - chip select rising latches the last 16 bits; earlier bits fall out
// - echo output repeats each input bit 15.5 clocks later, push-pull driven
// - in clock-input mode the shared pin clocks pwm, host supplies it
// - software chooses shared pin mode; only the power-up default differs
// - after power-up ports stay high impedance and do not act as inputs
// - device leaves power-up in shutdown
// - each port can be static or pwm sink, open-drain output or input
// - each current output has its own 8-bit pwm duty
// - each current output has its own half or full current select
// - one global 3-bit setting scales all sink currents
// - output code picks function: low, high/input, static, pwm, off
// - config bit 0 clear means shutdown, set means run
`timescale 1ns/1ps
`include "slpx_regs.svh"

module slpx_top #(
    parameter logic DEFAULT_PIN_CLKIN = 1'b0    // power-up mode of the shared pin
) (
    input  wire logic                i_sys_clk,     // system clock, 125 MHz
    input  wire logic                i_nrst,        // reset, active low, async
    input  wire logic                i_sclk,        // serial clock from host
    input  wire logic                i_cs_n,        // chip select, active low
    input  wire logic                i_sdi,         // serial data in
    output logic                     o_sdo,         // shared pin output value
    output logic                     o_sdo_oe,      // shared pin driven when high
    input  wire logic                i_shpin,       // shared pin level, pwm clock in
    input  wire logic [9:0]          i_port_in,     // io port line levels
    output logic [9:0]               o_port_oe,     // io port pulled low when high
    output logic [9:0]               o_sink_en,     // current sink on per port
    output logic [9:0]               o_sink_full,   // full current per port
    output logic [2:0]               o_gcur,        // global current scale
    output logic [9:0]               o_port_level,  // input level of input ports
    output logic                     o_run,         // high when out of shutdown
    output slpx_pkg::slpx_pin_mode_e o_pin_mode,    // shared pin mode
    output logic                     o_overflow     // word lost, fifo was full
);
    import slpx_pkg::*;

    //------------------------------------------------------------------
    // helpers
    //------------------------------------------------------------------

    // port function from its output code
    function automatic slpx_port_fn_e port_fn(input slpx_code_t code);
        if (code == `SLPX_CODE_LOW)
            return SLPX_FN_LOW;
        else if (code == `SLPX_CODE_HIGH)
            return SLPX_FN_HIGH;
        else if (code == `SLPX_CODE_STATIC)
            return SLPX_FN_STATIC;
        else if (code == `SLPX_CODE_OFF)
            return SLPX_FN_OFF;
        else
            return SLPX_FN_PWM;
    endfunction

    //------------------------------------------------------------------
    // reset release
    //------------------------------------------------------------------

    logic rst_meta_reg;
    logic rst_n_reg;

    // assert at once, release after two clean edges
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    //------------------------------------------------------------------
    // link domain on the serial clock
    //------------------------------------------------------------------

    logic [`SLPX_WORD_W-1:0] shift_reg;
    logic                    sdo_reg;

    // shift only inside a frame, the last 16 bits stay
    always_ff @(posedge i_sclk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            shift_reg <= '0;
        else if (!i_cs_n)
            shift_reg <= {shift_reg[`SLPX_WORD_W-2:0], i_sdi};
    end

    // bit out half a clock after the next bit goes in: 15.5 clocks of delay
    always_ff @(negedge i_sclk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            sdo_reg <= 1'b0;
        else if (!i_cs_n)
            sdo_reg <= shift_reg[`SLPX_WORD_W-1];
    end

    assign o_sdo = sdo_reg;

    //------------------------------------------------------------------
    // crossings into the system domain
    //------------------------------------------------------------------

    logic       cs_meta_reg;
    logic       cs_sync_reg;
    logic       cs_last_reg;
    logic       osc_meta_reg;
    logic       osc_sync_reg;
    logic       osc_last_reg;
    logic [9:0] pin_meta_reg;
    logic [9:0] pin_sync_reg;
    logic       cs_rise;
    logic       osc_rise;

    // chip select, external pwm clock and port levels each pass two flops
    always_ff @(posedge i_sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            cs_meta_reg  <= 1'b1;
            cs_sync_reg  <= 1'b1;
            cs_last_reg  <= 1'b1;
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_last_reg <= 1'b0;
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end
        else
        begin
            cs_meta_reg  <= i_cs_n;
            cs_sync_reg  <= cs_meta_reg;
            cs_last_reg  <= cs_sync_reg;
            osc_meta_reg <= i_shpin;
            osc_sync_reg <= osc_meta_reg;
            osc_last_reg <= osc_sync_reg;
            pin_meta_reg <= i_port_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign cs_rise  = cs_sync_reg && !cs_last_reg;
    assign osc_rise = osc_sync_reg && !osc_last_reg;

    //------------------------------------------------------------------
    // word capture into the fifo
    //------------------------------------------------------------------

    // the shift register is frozen while chip select is high, so the
    // word is taken whole once the synchronised rise is seen
    slpx_cap_e               cap_state_reg;
    logic [`SLPX_WORD_W-1:0] cap_word_reg;
    logic                    overflow_reg;
    logic                    fifo_in_ready;
    logic                    fifo_out_valid;
    logic [`SLPX_WORD_W-1:0] fifo_out_data;

    always_ff @(posedge i_sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            cap_state_reg <= SLPX_CAP_IDLE;
            cap_word_reg  <= '0;
            overflow_reg  <= 1'b0;
        end
        else
        begin
            case (cap_state_reg)
                SLPX_CAP_IDLE:
                begin
                    if (cs_rise)
                    begin
                        cap_word_reg  <= shift_reg;
                        cap_state_reg <= SLPX_CAP_PEND;
                    end
                end
                SLPX_CAP_PEND:
                begin
                    // a full fifo stalls the capture; a newer frame then is lost
                    if (cs_rise)
                        overflow_reg <= 1'b1;
                    if (fifo_in_ready)
                        cap_state_reg <= SLPX_CAP_IDLE;
                end
                default:
                    cap_state_reg <= SLPX_CAP_IDLE;
            endcase
        end
    end

    assign o_overflow = overflow_reg;

    //------------------------------------------------------------------
    // pwm timebase: internal divider or the shared pin clock
    //------------------------------------------------------------------

    logic [11:0] div_reg;
    logic        int_tick_reg;
    logic [7:0]  pwm_cnt_reg;
    logic        pwm_tick;
    slpx_pin_mode_e pin_mode_reg;

    always_ff @(posedge i_sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            div_reg      <= '0;
            int_tick_reg <= 1'b0;
        end
        else
        begin
            int_tick_reg <= (div_reg == 12'(`SLPX_INT_DIV - 1));
            if (div_reg == 12'(`SLPX_INT_DIV - 1))
                div_reg <= '0;
            else
                div_reg <= div_reg + 1'b1;
        end
    end

    // the external clock is only trusted while the pin is an input
    assign pwm_tick = (pin_mode_reg == SLPX_PIN_CLKIN) ? osc_rise : int_tick_reg;

    always_ff @(posedge i_sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            pwm_cnt_reg <= '0;
        else if (pwm_tick)
            pwm_cnt_reg <= pwm_cnt_reg + 1'b1;
    end

    //------------------------------------------------------------------
    // register writes drained from the fifo
    //------------------------------------------------------------------

    slpx_code_t  code_reg [10];
    logic        run_reg;
    logic [9:0]  full_reg;
    logic [2:0]  gcur_reg;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        wr_take;

    // a write is applied the cycle it leaves the fifo
    assign wr_addr = fifo_out_data[`SLPX_ADDR_HI:`SLPX_ADDR_LO];
    assign wr_data = fifo_out_data[`SLPX_DATA_HI:`SLPX_DATA_LO];
    // hold writes one cycle per pwm step so a duty change lands between steps
    assign wr_take = fifo_out_valid && !pwm_tick;

    always_ff @(posedge i_sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            for (int i = 0; i < 10; i++)
                code_reg[i] <= `SLPX_RST_CODE;
            run_reg      <= 1'b0;
            pin_mode_reg <= slpx_pin_mode_e'(DEFAULT_PIN_CLKIN);
            full_reg     <= `SLPX_RST_FULL;
            gcur_reg     <= `SLPX_RST_GCUR;
        end
        else if (wr_take)
        begin
            if (wr_addr <= `SLPX_A_PORT_LAST)
                code_reg[4'(wr_addr)] <= wr_data;
            else if (wr_addr == `SLPX_A_CFG)
            begin
                run_reg      <= wr_data[`SLPX_CFG_RUN];
                pin_mode_reg <= slpx_pin_mode_e'(wr_data[`SLPX_CFG_PINCLK]);
            end
            else if (wr_addr == `SLPX_A_FULL_LO)
                full_reg[7:0] <= wr_data;
            else if (wr_addr == `SLPX_A_FULL_HI)
                full_reg[9:8] <= wr_data[1:0];
            else if (wr_addr == `SLPX_A_GCUR)
                gcur_reg <= wr_data[2:0];
        end
    end

    slpx_fifo #(
        .WIDTH (`SLPX_WORD_W),
        .DEPTH (`SLPX_FIFO_DEPTH)
    ) u_fifo (
        .i_clk   (i_sys_clk),
        .i_rst_n (rst_n_reg),
        .i_valid (cap_state_reg == SLPX_CAP_PEND),
        .o_ready (fifo_in_ready),
        .i_data  (cap_word_reg),
        .o_valid (fifo_out_valid),
        .i_ready (wr_take),
        .o_data  (fifo_out_data)
    );

    //------------------------------------------------------------------
    // port drive
    //------------------------------------------------------------------

    // logic outputs ignore shutdown; current sinks go high impedance in it
    always_ff @(posedge i_sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            o_port_oe    <= '0;
            o_sink_en    <= '0;
            o_sink_full  <= '0;
            o_port_level <= '0;
        end
        else
        begin
            for (int i = 0; i < 10; i++)
            begin
                o_port_oe[i] <= (port_fn(code_reg[i]) == SLPX_FN_LOW);
                // duty is code over 256 steps of the pwm counter
                o_sink_en[i] <= run_reg &&
                    ((port_fn(code_reg[i]) == SLPX_FN_STATIC) ||
                     ((port_fn(code_reg[i]) == SLPX_FN_PWM) &&
                      (pwm_cnt_reg < code_reg[i])));
                o_sink_full[i] <= full_reg[i];
                // only a released port reads as an input
                o_port_level[i] <= (port_fn(code_reg[i]) == SLPX_FN_HIGH) &&
                                   pin_sync_reg[i];
            end
        end
    end

    // global scale and status
    always_ff @(posedge i_sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            o_gcur     <= `SLPX_RST_GCUR;
            o_run      <= 1'b0;
            o_pin_mode <= SLPX_PIN_DOUT;
            o_sdo_oe   <= 1'b0;
        end
        else
        begin
            o_gcur     <= gcur_reg;
            o_run      <= run_reg;
            o_pin_mode <= pin_mode_reg;
            // push-pull only while the pin is the data echo
            o_sdo_oe   <= (pin_mode_reg == SLPX_PIN_DOUT);
        end
    end

endmodule

// *** tb/serial_led_port_expander_if_bench.sv ***
// self-checking bench for the serial led port expander front end
`timescale 1ns/1ps
`include "slpx_regs.svh"

module serial_led_port_expander_if_bench;
    import slpx_pkg::*;

    logic           sys_clk;
    logic           nrst;
    logic           sclk;
    logic           cs_n;
    logic           sdi;
    logic           osc;
    logic           sdo;
    logic           sdo_oe;
    logic           shpin;
    logic [9:0]     port_in;
    logic [9:0]     port_oe;
    logic [9:0]     sink_en;
    logic [9:0]     sink_full;
    logic [2:0]     gcur;
    logic [9:0]     port_level;
    logic           run;
    logic           overflow;
    slpx_pin_mode_e pin_mode;
    logic [15:0]    prev;
    logic [15:0]    echo;
    logic           echo_ok;
    int             n_mismatch;
    int             checks;
    int             i;
    logic [7:0]     codes [5] = '{8'h00, 8'h01, 8'h02, 8'hFE, 8'hFF};

    // 125 MHz system clock
    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;

    // shared pin: the device drives it in data-output mode, else the host's clock
    assign shpin = sdo_oe ? sdo : osc;

    slpx_top u_dut (
        .i_sys_clk    (sys_clk),
        .i_nrst       (nrst),
        .i_sclk       (sclk),
        .i_cs_n       (cs_n),
        .i_sdi        (sdi),
        .o_sdo        (sdo),
        .o_sdo_oe     (sdo_oe),
        .i_shpin      (shpin),
        .i_port_in    (port_in),
        .o_port_oe    (port_oe),
        .o_sink_en    (sink_en),
        .o_sink_full  (sink_full),
        .o_gcur       (gcur),
        .o_port_level (port_level),
        .o_run        (run),
        .o_pin_mode   (pin_mode),
        .o_overflow   (overflow)
    );

    slpx_host u_host (
        .o_sclk (sclk),
        .o_cs_n (cs_n),
        .o_sdi  (sdi),
        .o_osc  (osc),
        .i_sdo  (shpin)
    );

    // ----------------------------------------
    // comparison, frames and the verdict
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // echo of a whole word is the word before it; wait covers latch plus pwm stalls
    task automatic xfer(input logic [15:0] word, input int extra);
        @(negedge sys_clk);
        u_host.frame(word, extra, echo);
        if (echo_ok && extra == 0)
            check(32'(echo), 32'(prev));
        prev = word;
        repeat (12) @(negedge sys_clk);
        echo_ok = (sdo_oe === 1'b1);
    endtask

    task automatic end_of_test;
        if (n_mismatch == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        nrst       = 1'b0;
        port_in    = 10'h2AA;
        n_mismatch = 0;
        checks     = 0;
        echo_ok    = 1'b0;
        prev       = 16'h0000;
        repeat (8) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (6) @(negedge sys_clk);
        // power-up: ports released, shutdown, shared pin as data output
        check(32'({port_oe, sink_en, port_level}), 32'h0);
        check(32'({run, gcur, pin_mode, sdo_oe}), 32'h1D);
        // clock-input mode: the pwm counter steps only on the host's clock
        xfer({`SLPX_A_CFG, 8'h03}, 0);
        check(32'({pin_mode, sdo_oe}), 32'h2);
        xfer({8'h02, `SLPX_CODE_PWM_MIN}, 0);
        check(32'(sink_en[2]), 32'h1);
        u_host.ticks(3);
        repeat (6) @(negedge sys_clk);
        check(32'(sink_en[2]), 32'h0);
        // back to data output, then one code per port function
        xfer({`SLPX_A_CFG, 8'h01}, 0);
        check(32'({pin_mode, sdo_oe}), 32'h1);
        for (i = 0; i < 5; i++)
            xfer({i[7:0], codes[i]}, 0);
        check(32'(port_oe[4:0]), 32'h01);
        check(32'(sink_en[4:0]), 32'h0C);
        check(32'(port_level), 32'({port_in[1], 1'b0}));
        port_in = 10'h155;
        repeat (6) @(negedge sys_clk);
        check(32'(port_level), 32'({port_in[1], 1'b0}));
        // per-port full current and the global scale
        xfer({`SLPX_A_FULL_LO, 8'hA5}, 0);
        xfer({`SLPX_A_FULL_HI, 8'h02}, 0);
        xfer({`SLPX_A_GCUR, 8'h03}, 0);
        check(32'(sink_full), 32'h2A5);
        check(32'(gcur), 32'h3);
        // long burst: only the last sixteen bits count, here a shutdown
        xfer({`SLPX_A_CFG, 8'h00}, 8);
        check(32'(run), 32'h0);
        check(32'({port_oe, sink_en}), 32'({10'h001, 10'h000}));
        // clocks while deselected must not disturb the next word
        u_host.stray(5);
        xfer({`SLPX_A_CFG, 8'h01}, 0);
        check(32'(sink_en[4:0]), 32'h0C);
        // an unmapped address leaves every setting alone; no word was lost
        xfer({8'h20, 8'h00}, 0);
        check(32'({overflow, run, port_oe, sink_full}), 32'({2'b01, 10'h001, 10'h2A5}));
        end_of_test;
    end

    // cut a hang short; the sequence needs well under 200 us
    initial
    begin
        #500000;
        n_mismatch++;
        end_of_test;
    end
endmodule

// *** tb/slpx_checker.sv ***
// concurrent checks on the ports of the front end top
`timescale 1ns/1ps

module slpx_checker
    import slpx_pkg::*;
(
    input wire logic           i_sys_clk,    // system clock
    input wire logic           i_nrst,       // reset, active low
    input wire logic           i_sclk,       // serial clock
    input wire logic           i_cs_n,       // chip select
    input wire logic           i_sdi,        // serial data in
    input wire logic           o_sdo,        // echo data
    input wire logic           o_sdo_oe,     // shared pin drive
    input wire logic           i_shpin,      // shared pin level
    input wire logic [9:0]     i_port_in,    // port levels
    input wire logic [9:0]     o_port_oe,    // port pulled low
    input wire logic [9:0]     o_sink_en,    // sink on
    input wire logic [9:0]     o_sink_full,  // full current
    input wire logic [2:0]     o_gcur,       // global scale
    input wire logic [9:0]     o_port_level, // input levels
    input wire logic           o_run,        // run flag
    input wire slpx_pin_mode_e o_pin_mode,   // shared pin mode
    input wire logic           o_overflow    // word lost
);
    logic [15:0] shadow_reg;
    logic [4:0]  fill_reg;

    // mirror of the last sixteen bits shifted in; fill tells when it is complete
    always_ff @(posedge i_sclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            shadow_reg <= 16'h0000;
            fill_reg   <= 5'h00;
        end
        else if (!i_cs_n)
        begin
            shadow_reg <= {shadow_reg[14:0], i_sdi};
            fill_reg   <= (fill_reg == 5'h10) ? fill_reg : fill_reg + 5'h01;
        end
    end

    sequence s_reset_gone;
        $rose(i_nrst);
    endsequence

    sequence s_echo_ready;
        !i_cs_n && fill_reg == 5'h10 && o_sdo_oe;
    endsequence

    property p_echo;
        @(posedge i_sclk) disable iff (!i_nrst) s_echo_ready |-> o_sdo == shadow_reg[15];
    endproperty
    a_echo: assert property (p_echo)
        else $error("echo bit is not the input bit of 15.5 clocks before");

    property p_cs_quiet;
        @(posedge i_sclk) disable iff (!i_nrst) i_cs_n && $past(i_cs_n) |-> $stable(o_sdo);
    endproperty
    a_cs_quiet: assert property (p_cs_quiet)
        else $error("echo moved while deselected");

    property p_reset_shut;
        @(posedge i_sys_clk) disable iff (!i_nrst) s_reset_gone |-> (!o_run) [*8];
    endproperty
    a_reset_shut: assert property (p_reset_shut)
        else $error("not in shutdown after reset");

    property p_reset_hiz;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        s_reset_gone |-> (o_port_oe == 10'h000 && o_sink_en == 10'h000
                          && o_port_level == 10'h000) [*8];
    endproperty
    a_reset_hiz: assert property (p_reset_hiz)
        else $error("port active after reset");

    property p_gcur_reset;
        @(posedge i_sys_clk) disable iff (!i_nrst) s_reset_gone |-> o_gcur == 3'h7;
    endproperty
    a_gcur_reset: assert property (p_gcur_reset)
        else $error("global scale wrong after reset");

    property p_shut_sinks;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !o_run && !$past(o_run) |-> o_sink_en == 10'h000;
    endproperty
    a_shut_sinks: assert property (p_shut_sinks)
        else $error("sink on during shutdown");

    property p_oe_mode;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        $changed(o_pin_mode) |=> o_sdo_oe == (o_pin_mode == SLPX_PIN_DOUT);
    endproperty
    a_oe_mode: assert property (p_oe_mode)
        else $error("shared pin drive does not follow its mode");

    property p_low_excl;
        @(posedge i_sys_clk) disable iff (!i_nrst) (o_port_oe & o_sink_en) == 10'h000;
    endproperty
    a_low_excl: assert property (p_low_excl)
        else $error("port pulled low and sinking at once");

    property p_input_excl;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (o_port_level & (o_port_oe | o_sink_en)) == 10'h000;
    endproperty
    a_input_excl: assert property (p_input_excl)
        else $error("driven port reports an input level");

    // a word acts only after chip select has risen and stayed high
    property p_run_after_cs;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        $changed(o_run) |-> $past(i_cs_n, 4) && $past(i_cs_n, 5);
    endproperty
    a_run_after_cs: assert property (p_run_after_cs)
        else $error("run flag changed before the word latched");
endmodule

bind slpx_top slpx_checker u_chk (.i_sys_clk, .i_nrst, .i_sclk, .i_cs_n, .i_sdi, .o_sdo,
    .o_sdo_oe, .i_shpin, .i_port_in, .o_port_oe, .o_sink_en, .o_sink_full, .o_gcur,
    .o_port_level, .o_run, .o_pin_mode, .o_overflow);

// *** tb/slpx_host.sv ***
// host model: serial master of the front end and source of the external pwm clock
`timescale 1ns/1ps

module slpx_host (
    output logic      o_sclk,   // serial clock, still outside frames except during stray
    output logic      o_cs_n,   // chip select, active low
    output logic      o_sdi,    // serial data towards the device
    output logic      o_osc,    // pwm clock, used in clock-input mode
    input  wire logic i_sdo     // level seen on the shared pin
);
    // idle bus: select high, clocks parked low
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi  = 1'b0;
        o_osc  = 1'b0;
    end

    // one frame: extra lead bits of junk, then the word, msb first, 80 ns bit time
    task automatic frame(input logic [15:0] word, input int extra, output logic [15:0] echo);
        int k;
        #3;
        o_cs_n = 1'b0;
        for (k = extra + 15; k >= 0; k--)
        begin
            o_sdi = (k > 15) ? k[0] : word[k];
            #40;
            echo = {echo[14:0], i_sdo};
            o_sclk = 1'b1;
            #40;
            o_sclk = 1'b0;
        end
        #20;
        o_cs_n = 1'b1;
        // no pull on the data line, so it must not look held
        o_sdi = ~o_sdi;
    endtask

    // serial clocks while deselected; the data line wanders meanwhile
    task automatic stray(input int n);
        repeat (n)
        begin
            #40;
            o_sclk = 1'b1;
            o_sdi  = ~o_sdi;
            #40;
            o_sclk = 1'b0;
        end
    endtask

    // external pwm clock at 100 kHz, n rising edges
    task automatic ticks(input int n);
        repeat (n)
        begin
            #5000;
            o_osc = 1'b1;
            #5000;
            o_osc = 1'b0;
        end
    endtask
endmodule
